// ==== dv/pmc_host.sv ====
// Behavioural host on the two-wire management bus.
// Assumes a pull-up on the data wire; paced by the bench clock.
`timescale 1ns/1ps
`default_nettype none
module pmc_host (
  input wire logic clk, // Pacing clock.
  input wire logic sda, // Resolved data wire.
  output logic scl, // Serial clock, 80 ns period.
  output logic sda_h // Host data drive, one releases.
);
  initial begin
    scl = 1'b1;
    sda_h = 1'b1;
  end
  // Serial clock stands high between frames, as an idle bus does.
  task automatic q;
    repeat (4) @(negedge clk);
  endtask : q
  task automatic start;
    sda_h = 1'b1;
    q;
    scl = 1'b1;
    q;
    sda_h = 1'b0;
    q;
    scl = 1'b0;
    q;
  endtask : start
  task automatic stop;
    sda_h = 1'b0;
    q;
    scl = 1'b1;
    q;
    sda_h = 1'b1;
    q;
  endtask : stop
  task automatic xfer(input logic [8:0] d, output logic [8:0] r);
    for (int i = 8; i >= 0; i--) begin
      sda_h = d[i];
      q;
      scl = 1'b1;
      q;
      r[i] = sda;
      q;
      scl = 1'b0;
      q;
    end
  endtask : xfer
  // Raw bytes are taken so that refused frames can be sent too.
  task automatic wr(input logic [7:0] ab, input logic [7:0] rb,
                    input logic [15:0] v, output logic ok);
    logic [8:0] r0, r1, r2, r3;
    start;
    xfer({ab, 1'b1}, r0);
    xfer({rb, 1'b1}, r1);
    xfer({v[15:8], 1'b1}, r2);
    xfer({v[7:0], 1'b1}, r3);
    stop;
    ok = !(r0[0] | r1[0] | r2[0] | r3[0]);
  endtask : wr
  task automatic rd(input logic [7:0] rb, output logic [15:0] v,
                    output logic ok);
    logic [8:0] r0, r1, r2, hi, lo;
    start;
    xfer({8'hac, 1'b1}, r0);
    xfer({rb, 1'b1}, r1);
    start;
    xfer({8'had, 1'b1}, r2);
    xfer({8'hff, 1'b0}, hi);
    xfer({8'hff, 1'b1}, lo);
    stop;
    v = {hi[8:1], lo[8:1]};
    ok = !(r0[0] | r1[0] | r2[0]);
  endtask : rd
endmodule : pmc_host
`default_nettype wire

// ==== dv/pmc_regs_chk.sv ====
// Port assertions for the management register bank.
// Bound into every pmc_regs; sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module pmc_regs_chk #(
  parameter int SRST_CYCLES = 16
) (
  input wire logic clk, // System clock.
  input wire logic rst_n, // Reset, active low.
  input wire logic scl, // Serial clock pin.
  input wire logic sda_out, // Data drive value.
  input wire logic sda_oe, // Data pull enable.
  input wire logic phy_soft_reset, // Soft reset running.
  input wire logic loopback_en, // Loopback.
  input wire logic an_enable, // Negotiation in force.
  input wire logic an_restart, // Restart pulse.
  input wire logic power_down, // Power-down.
  input wire logic isolate, // Isolate.
  input wire logic collision_test, // Collision test.
  input wire logic speed_1000, // Working speed.
  input wire logic duplex_full // Full duplex.
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  int srst_len;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      srst_len <= 0;
    end else begin
      srst_len <= phy_soft_reset ? srst_len + 1 : 0;
    end
  end
  AST_OPEN_DRAIN: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  AST_HW_RESET: assert property ($rose(rst_n) |->
    !sda_oe && !loopback_en && !power_down && !isolate && !collision_test
    && !an_enable && !phy_soft_reset && speed_1000 && duplex_full)
    else $error("outputs not at reset values");
  AST_SRST_LEN: assert property ($fell(phy_soft_reset) |->
    srst_len == SRST_CYCLES) else $error("soft reset length wrong");
  AST_SRST_CLEARS: assert property ($fell(phy_soft_reset) |->
    ##[0:1] !(loopback_en || power_down || isolate || collision_test))
    else $error("soft reset left a mode bit set");
  AST_AN_HELD: assert property ($changed(an_enable) |->
    $past(phy_soft_reset) || $past(phy_soft_reset, 2))
    else $error("negotiation enable changed outside soft reset");
  AST_AN_MODE: assert property (an_enable |=> speed_1000 && duplex_full)
    else $error("manual speed or duplex used while negotiating");
  AST_RESTART_PULSE: assert property (an_restart |=> !an_restart)
    else $error("restart not self clearing");
  AST_ACK_IN_LOW: assert property ($changed(sda_oe) |-> !scl)
    else $error("data pin changed while serial clock high");
  COV_SRST: cover property ($fell(phy_soft_reset));
  COV_RESTART: cover property (an_restart);
  COV_ACK: cover property ($rose(sda_oe));
  COV_AN: cover property ($rose(an_enable));
endmodule : pmc_regs_chk
bind pmc_regs pmc_regs_chk #(.SRST_CYCLES(SRST_CYCLES)) u_chk (
  .clk(clk), .rst_n(rst_n), .scl(scl), .sda_out(sda_out), .sda_oe(sda_oe),
  .phy_soft_reset(phy_soft_reset), .loopback_en(loopback_en),
  .an_enable(an_enable), .an_restart(an_restart), .power_down(power_down),
  .isolate(isolate), .collision_test(collision_test),
  .speed_1000(speed_1000), .duplex_full(duplex_full));
`default_nettype wire

// ==== dv/testbench.sv ====
// Self-checking bench for the management register bank.
// Drives the bus through pmc_host; live status comes from here.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk, rst_n, an_complete, remote_fault, link_up, jabber;
  logic scl, sda_h, sda_out, sda_oe;
  logic phy_soft_reset, loopback_en, an_enable, an_restart, power_down;
  logic isolate, collision_test, speed_1000, duplex_full, ok;
  int n_mismatch = 0;
  int compares = 0;
  int n_restart = 0;
  wire sda = sda_oe ? (sda_out & sda_h) : sda_h;
  wire [7:0] outs = {phy_soft_reset, loopback_en, an_enable, power_down,
    isolate, collision_test, speed_1000, duplex_full};
  pmc_regs #(.SRST_CYCLES(2)) dut (.clk(clk), .rst_n(rst_n), .scl(scl),
    .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .an_complete(an_complete), .remote_fault(remote_fault),
    .link_up(link_up), .jabber(jabber), .phy_soft_reset(phy_soft_reset),
    .loopback_en(loopback_en), .an_enable(an_enable),
    .an_restart(an_restart), .power_down(power_down), .isolate(isolate),
    .collision_test(collision_test), .speed_1000(speed_1000),
    .duplex_full(duplex_full));
  pmc_host host (.clk(clk), .sda(sda), .scl(scl), .sda_h(sda_h));
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    if (an_restart === 1'b1) begin
      n_restart++;
    end
  end
  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wreg(input logic [4:0] a, input logic [15:0] v);
    host.wr(8'hac, {3'h0, a}, v, ok);
    chk("write ack", {15'h0, ok}, 16'h0001);
  endtask : wreg
  task automatic rreg(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] v;
    host.rd({3'h0, a}, v, ok);
    chk("read ack", {15'h0, ok}, 16'h0001);
    chk("read data", v, exp);
  endtask : rreg
  task automatic t_reset;
    chk("outputs", {8'h0, outs}, 16'h0003);
    rreg(5'h00, 16'h0140);
    rreg(5'h01, 16'h0149);
    rreg(5'h01, 16'h014d);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_sticky;
    remote_fault = 1'b1;
    jabber = 1'b1;
    link_up = 1'b0;
    repeat (4) @(negedge clk);
    remote_fault = 1'b0;
    jabber = 1'b0;
    link_up = 1'b1;
    an_complete = 1'b1;
    rreg(5'h01, 16'h017b);
    rreg(5'h01, 16'h016d);
    remote_fault = 1'b1;
    rreg(5'h01, 16'h017d);
    remote_fault = 1'b0;
    rreg(5'h01, 16'h017d);
    rreg(5'h01, 16'h016d);
    $display("t_sticky done");
  endtask : t_sticky
  task automatic t_ctrl;
    wreg(5'h00, 16'h4c80);
    chk("outputs", {8'h0, outs}, 16'h005c);
    rreg(5'h00, 16'h4c80);
    wreg(5'h00, 16'h2040);
    chk("outputs", {8'h0, outs}, 16'h0000);
    wreg(5'h00, 16'h013f);
    chk("outputs", {8'h0, outs}, 16'h0001);
    rreg(5'h00, 16'h013f);
    $display("t_ctrl done");
  endtask : t_ctrl
  task automatic t_restart;
    n_restart = 0;
    wreg(5'h00, 16'h0340);
    chk("restart pulses", n_restart[15:0], 16'h0001);
    rreg(5'h00, 16'h0140);
    $display("t_restart done");
  endtask : t_restart
  task automatic t_srst;
    wreg(5'h00, 16'h5d40);
    chk("outputs", {8'h0, outs}, 16'h005b);
    wreg(5'h00, 16'hdd40);
    chk("outputs", {8'h0, outs}, 16'h0023);
    rreg(5'h00, 16'h1140);
    wreg(5'h00, 16'h1000);
    chk("outputs", {8'h0, outs}, 16'h0023);
    wreg(5'h00, 16'h8000);
    chk("outputs", {8'h0, outs}, 16'h0000);
    $display("t_srst done");
  endtask : t_srst
  task automatic t_refuse;
    logic [15:0] v;
    host.wr(8'ha0, 8'h00, 16'h4000, ok);
    chk("foreign address ack", {15'h0, ok}, 16'h0000);
    host.wr(8'hac, 8'h20, 16'h4000, ok);
    chk("bad pointer ack", {15'h0, ok}, 16'h0000);
    host.wr(8'hac, 8'h01, 16'hffff, ok);
    host.wr(8'hac, 8'h02, 16'hffff, ok);
    rreg(5'h00, 16'h0000);
    host.rd(8'h01, v, ok);
    chk("read ack", {15'h0, ok}, 16'h0001);
    chk("status after soft reset", v, 16'h0169);
    rreg(5'h01, 16'h016d);
    rreg(5'h02, 16'h0000);
    $display("t_refuse done");
  endtask : t_refuse
  task automatic end_of_test;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_of_test
  initial begin
    clk = 1'b0;
    rst_n = 1'b0;
    an_complete = 1'b0;
    remote_fault = 1'b0;
    link_up = 1'b1;
    jabber = 1'b0;
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset;
    t_sticky;
    t_ctrl;
    t_restart;
    t_srst;
    t_refuse;
    end_of_test;
  end
  // About thirty frames of under 4 us each; four times that is ample.
  initial begin
    #400000;
    n_mismatch++;
    end_of_test;
  end
endmodule : testbench
`default_nettype wire

// ==== verilog/pmc_defs.svh ====
// Constants for the management register bank: bus address, register
// numbers, control and status bit positions, reset values and counts.
// Included by pmc_regs, the only design file of the bank using it; holds definitions only.
`ifndef PMC_DEFS_SVH
`define PMC_DEFS_SVH

// Seven-bit address on the two-wire bus.
`define PMC_DEV_ADDR 7'h56
// The register address byte carries zeros in its top three bits.
`define PMC_REGADDR_PAD 3'h0
`define PMC_REG_CTRL 5'h00
`define PMC_REG_STAT 5'h01
`define PMC_WORD_ZERO 16'h0000
`define PMC_BIT_LAST 3'h7

// Control register bits.
`define PMC_C_SRST 15
`define PMC_C_LOOP 14
`define PMC_C_SPD_L 13
`define PMC_C_AN_EN 12
`define PMC_C_PDN 11
`define PMC_C_ISO 10
`define PMC_C_AN_RST 9
`define PMC_C_DUP 8
`define PMC_C_COL 7
`define PMC_C_SPD_M 6
`define PMC_CTRL_RST_VAL 16'h0140

// Status register bits.
`define PMC_S_XSTAT 8
`define PMC_S_PREAMB 6
`define PMC_S_AN_DONE 5
`define PMC_S_RFAULT 4
`define PMC_S_AN_ABLE 3
`define PMC_S_LINK 2
`define PMC_S_JAB 1
`define PMC_S_XCAP 0

// Length of the software reset of the physical-layer logic, in clocks.
`define PMC_SRST_CYCLES 16

`endif

// ==== verilog/pmc_pkg.sv ====
// Types shared by the management register bank.
// Assumes nothing of its surroundings.
`default_nettype none
package pmc_pkg;
  // States of the two-wire bus slave.
  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_ack,
    st_rx,
    st_tx,
    st_mack,
    st_wait
  } pmc_state_t;
endpackage : pmc_pkg
`default_nettype wire

// ==== verilog/pmc_regs.sv ====
// Management register bank of the physical-layer logic, reached over a
// two-wire serial bus. The bus pins are sampled by clk, which must run
// far faster than the serial clock; live status comes from logic on clk.
//
// Operation
// - Thirty-two sixteen-bit registers, each bit read-only or read-write.
// - Answers bus address 1010110, eighth address bit chooses read or write.
// - Register address byte is three zero bits then the register number.
// - Every register access moves sixteen bits in one multi-byte transfer.
// - Only certain register numbers are defined; here control and status.
// - Control bit 15 starts a software reset and clears itself after.
// - Control bit 14 loops received serial data back to the transmitter.
// - Bits 13 and 6 pick speed; only 1000 works, used without negotiation.
// - Negotiation enable bit 12 takes effect only after a software reset.
// - Control bit 11 powers down; software reset clears it.
// - Control bit 10 isolates the data interface; both resets clear it.
// - Control bit 9 restarts negotiation and clears itself.
// - Control bit 8 selects full duplex, resets to one, manual mode only.
// - Control bit 7 enables the collision signal test; resets clear it.
// - Status bits 8, 6, 3, 0 read one; bits 15 to 9 and 7 read zero.
// - Frames without preamble are accepted; status bit 6 reads one.
// - Status bit 5 shows negotiation complete, live; neither reset clears it.
// - Status bit 4 latches a remote fault high until read.
// - Status bit 2 shows link and latches low on loss until read.
// - Status bit 1 latches a jabber condition high until read.
`timescale 1ns/1ps
`default_nettype none
`include "pmc_defs.svh"
module pmc_regs
  import pmc_pkg::*;
#(
  parameter int SRST_CYCLES = `PMC_SRST_CYCLES
) (
  input wire logic clk, // System clock, 200 MHz.
  input wire logic rst_n, // Asynchronous hardware reset, active low.
  input wire logic scl, // Serial clock pin.
  input wire logic sda_in, // Serial data pin level.
  output logic sda_out, // Serial data drive value, always low.
  output logic sda_oe, // Serial data pulled low while high.
  input wire logic an_complete, // Negotiation complete, live.
  input wire logic remote_fault, // Remote fault, live.
  input wire logic link_up, // Link up, live.
  input wire logic jabber, // Jabber condition, live.
  output logic phy_soft_reset, // Software reset in progress.
  output logic loopback_en, // Serial loopback enabled.
  output logic an_enable, // Negotiation enable in force.
  output logic an_restart, // One-cycle negotiation restart.
  output logic power_down, // Power-down requested.
  output logic isolate, // Data interface isolated.
  output logic collision_test, // Collision signal test enabled.
  output logic speed_1000, // Speed setting is a working one.
  output logic duplex_full // Full duplex in force.
);
  localparam int CW = $clog2(SRST_CYCLES + 1);

  logic s_scl, s_sda, scl_q, sda_q;
  logic scl_rise, scl_fall, bus_start, bus_stop;
  pmc_state_t state;
  logic [2:0] bit_cnt;
  logic [7:0] shreg, lo_byte, wr_hi;
  logic [1:0] byte_idx;
  logic got_byte, is_read, host_ack, tx_lo;
  logic [4:0] ptr, wr_addr;
  logic wr_stb, rd_done;
  logic [15:0] wr_data, rd_word, phy_control, phy_status;
  logic [CW-1:0] srst_cnt;
  logic srst_load, srst_end;
  logic fault_sh, link_sl, jab_sh;

  // The bus pins come from the far side and are resynchronised first.
  pmc_sync #(
    .W(2)
  ) u_sync (
    .clk(clk),
    .rst_n(rst_n),
    .async_in({scl, sda_in}),
    .sync_out({s_scl, s_sda})
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= s_scl;
      sda_q <= s_sda;
    end
  end

  assign scl_rise = s_scl & ~scl_q;
  assign scl_fall = ~s_scl & scl_q;
  assign bus_start = s_scl & scl_q & sda_q & ~s_sda;
  assign bus_stop = s_scl & scl_q & ~sda_q & s_sda;
  assign sda_out = 1'b0;

  // Read data for the register under the pointer; unlisted numbers
  // belong to other parts of the chip and read as zero here.
  always_comb begin
    unique case (ptr)
      `PMC_REG_CTRL: rd_word = phy_control;
      `PMC_REG_STAT: rd_word = phy_status;
      default: rd_word = `PMC_WORD_ZERO;
    endcase
  end

  // Bus slave. Bits are taken on the serial clock rise and driven
  // after its fall, so the host always sees a settled data line.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_idle;
      bit_cnt <= 3'h0;
      shreg <= 8'h00;
      lo_byte <= 8'h00;
      wr_hi <= 8'h00;
      byte_idx <= 2'h0;
      got_byte <= 1'b0;
      is_read <= 1'b0;
      host_ack <= 1'b0;
      tx_lo <= 1'b0;
      ptr <= 5'h00;
      wr_addr <= 5'h00;
      wr_stb <= 1'b0;
      wr_data <= 16'h0000;
      rd_done <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      wr_stb <= 1'b0;
      rd_done <= 1'b0;
      if (bus_start) begin
        // No preamble is needed: any start opens a new frame.
        state <= st_addr;
        bit_cnt <= 3'h0;
        got_byte <= 1'b0;
        sda_oe <= 1'b0;
      end else if (bus_stop) begin
        state <= st_idle;
        sda_oe <= 1'b0;
      end else begin
        unique case (state)
          st_idle, st_wait: begin
            sda_oe <= 1'b0;
          end
          st_addr, st_rx: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], s_sda};
              bit_cnt <= bit_cnt + 3'h1;
              got_byte <= (bit_cnt == `PMC_BIT_LAST);
            end else if (scl_fall && got_byte) begin
              got_byte <= 1'b0;
              state <= st_ack;
              sda_oe <= 1'b1;
              if (state == st_addr) begin
                is_read <= shreg[0];
                byte_idx <= 2'h1;
                if (shreg[7:1] != `PMC_DEV_ADDR) begin
                  state <= st_wait;
                  sda_oe <= 1'b0;
                end
              end else if (byte_idx == 2'h1) begin
                ptr <= shreg[4:0];
                byte_idx <= 2'h2;
                if (shreg[7:5] != `PMC_REGADDR_PAD) begin
                  state <= st_wait;
                  sda_oe <= 1'b0;
                end
              end else if (byte_idx == 2'h2) begin
                wr_hi <= shreg;
                byte_idx <= 2'h3;
              end else begin
                // A word is written only once both bytes are in.
                wr_stb <= 1'b1;
                wr_addr <= ptr;
                wr_data <= {wr_hi, shreg};
                ptr <= ptr + 5'h01;
                byte_idx <= 2'h2;
              end
            end
          end
          st_ack: begin
            if (scl_fall) begin
              bit_cnt <= 3'h0;
              if (is_read) begin
                // The low byte is captured with the high one so that
                // both halves come from the same instant.
                shreg <= rd_word[15:8];
                lo_byte <= rd_word[7:0];
                sda_oe <= ~rd_word[15];
                tx_lo <= 1'b0;
                state <= st_tx;
              end else begin
                sda_oe <= 1'b0;
                state <= st_rx;
              end
            end
          end
          st_tx: begin
            if (scl_rise) begin
              bit_cnt <= bit_cnt + 3'h1;
              got_byte <= (bit_cnt == `PMC_BIT_LAST);
            end else if (scl_fall) begin
              if (got_byte) begin
                got_byte <= 1'b0;
                sda_oe <= 1'b0;
                state <= st_mack;
                if (tx_lo) begin
                  rd_done <= (ptr == `PMC_REG_STAT);
                  ptr <= ptr + 5'h01;
                end
              end else begin
                shreg <= {shreg[6:0], 1'b0};
                sda_oe <= ~shreg[6];
              end
            end
          end
          st_mack: begin
            if (scl_rise) begin
              host_ack <= ~s_sda;
            end else if (scl_fall) begin
              bit_cnt <= 3'h0;
              if (!host_ack) begin
                state <= st_wait;
              end else if (tx_lo) begin
                shreg <= rd_word[15:8];
                lo_byte <= rd_word[7:0];
                sda_oe <= ~rd_word[15];
                tx_lo <= 1'b0;
                state <= st_tx;
              end else begin
                shreg <= lo_byte;
                sda_oe <= ~lo_byte[7];
                tx_lo <= 1'b1;
                state <= st_tx;
              end
            end
          end
        endcase
      end
    end
  end

  assign srst_load = wr_stb && (wr_addr == `PMC_REG_CTRL)
                     && wr_data[`PMC_C_SRST];
  // A control write landing on the last reset cycle holds the timer one
  // clock more, so the clearing below is never skipped by that write.
  assign srst_end = (srst_cnt == CW'(1))
                    && !(wr_stb && (wr_addr == `PMC_REG_CTRL));

  // Software reset timer; a fresh request restarts it.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      srst_cnt <= '0;
    end else if (srst_load) begin
      srst_cnt <= CW'(SRST_CYCLES);
    end else if ((srst_cnt > CW'(1)) || srst_end) begin
      srst_cnt <= srst_cnt - CW'(1);
    end
  end

  // Control register. Speed, negotiation enable and duplex survive a
  // software reset; the other working bits return to zero.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phy_control <= `PMC_CTRL_RST_VAL;
      an_enable <= 1'b0;
    end else begin
      phy_control[`PMC_C_AN_RST] <= 1'b0;
      if (wr_stb && (wr_addr == `PMC_REG_CTRL)) begin
        phy_control <= wr_data;
        // A write without bit 15 cannot cut a running reset short.
        phy_control[`PMC_C_SRST] <= wr_data[`PMC_C_SRST]
                                    | (srst_cnt != '0);
      end else if (srst_end) begin
        phy_control[`PMC_C_SRST] <= 1'b0;
        phy_control[`PMC_C_LOOP] <= 1'b0;
        phy_control[`PMC_C_PDN] <= 1'b0;
        phy_control[`PMC_C_ISO] <= 1'b0;
        phy_control[`PMC_C_COL] <= 1'b0;
        an_enable <= phy_control[`PMC_C_AN_EN];
      end
    end
  end

  assign phy_soft_reset = phy_control[`PMC_C_SRST];
  assign loopback_en = phy_control[`PMC_C_LOOP];
  assign power_down = phy_control[`PMC_C_PDN];
  assign isolate = phy_control[`PMC_C_ISO];
  assign an_restart = phy_control[`PMC_C_AN_RST];
  assign collision_test = phy_control[`PMC_C_COL];

  // Speed and duplex bits only steer the link in manual mode; with
  // negotiation in force the link runs at 1000 full duplex.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      speed_1000 <= 1'b1;
      duplex_full <= 1'b1;
    end else begin
      speed_1000 <= an_enable
                    | (~phy_control[`PMC_C_SPD_L]
                       & phy_control[`PMC_C_SPD_M]);
      duplex_full <= an_enable | phy_control[`PMC_C_DUP];
    end
  end

  pmc_sticky u_sticky (
    .clk(clk),
    .rst_n(rst_n),
    .clr(rd_done),
    .flush(srst_end),
    .fault_live(remote_fault),
    .link_live(link_up),
    .jabber_live(jabber),
    .fault_sticky_high(fault_sh),
    .link_sticky_low(link_sl),
    .jabber_sticky_high(jab_sh)
  );

  always_comb begin
    phy_status = `PMC_WORD_ZERO;
    phy_status[`PMC_S_XSTAT] = 1'b1;
    phy_status[`PMC_S_PREAMB] = 1'b1;
    phy_status[`PMC_S_AN_DONE] = an_complete;
    phy_status[`PMC_S_RFAULT] = fault_sh;
    phy_status[`PMC_S_AN_ABLE] = 1'b1;
    phy_status[`PMC_S_LINK] = link_sl;
    phy_status[`PMC_S_JAB] = jab_sh;
    phy_status[`PMC_S_XCAP] = 1'b1;
  end
endmodule : pmc_regs
`default_nettype wire

// ==== verilog/pmc_sticky.sv ====
// Latched status flags of the status register.
// Assumes the live conditions are levels on clk and clr is a one-cycle
// pulse marking a completed host read of the status register.
`timescale 1ns/1ps
`default_nettype none
module pmc_sticky (
  input wire logic clk, // System clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic clr, // Status register read completed.
  input wire logic flush, // Software reset finished.
  input wire logic fault_live, // Remote fault condition now.
  input wire logic link_live, // Link up now.
  input wire logic jabber_live, // Jabber condition now.
  output logic fault_sticky_high, // Latched remote fault.
  output logic link_sticky_low, // Latched link status.
  output logic jabber_sticky_high // Latched jabber.
);
  // A live event in the clearing cycle still sets the flag.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_sticky_high <= 1'b0;
      jabber_sticky_high <= 1'b0;
    end else if (flush) begin
      fault_sticky_high <= 1'b0;
      jabber_sticky_high <= 1'b0;
    end else begin
      fault_sticky_high <= (fault_sticky_high & ~clr) | fault_live;
      jabber_sticky_high <= (jabber_sticky_high & ~clr) | jabber_live;
    end
  end

  // A drop of link holds the flag low until a read lets it follow again.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      link_sticky_low <= 1'b0;
    end else if (flush) begin
      link_sticky_low <= 1'b0;
    end else if (clr) begin
      link_sticky_low <= link_live;
    end else begin
      link_sticky_low <= link_sticky_low & link_live;
    end
  end
endmodule : pmc_sticky
`default_nettype wire

// ==== verilog/pmc_sync.sv ====
// Two-stage synchroniser for levels that arrive from outside clk.
// Assumes each bit is an independent level; no word coherence is given.
`timescale 1ns/1ps
`default_nettype none
module pmc_sync #(
  parameter int W = 2
) (
  input wire logic clk, // Sampling clock.
  input wire logic rst_n, // Asynchronous reset, active low.
  input wire logic [W-1:0] async_in, // Levels from another domain.
  output logic [W-1:0] sync_out // Synchronised levels.
);
  logic [W-1:0] meta;

  // The first stage feeds the second stage and nothing else.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta <= '1;
      sync_out <= '1;
    end else begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule : pmc_sync
`default_nettype wire
